// ===== verilog/vmeirq_pkg.sv
// How it works
// - each enabled level latches the 8-bit vector returned by its acknowledge.
// - level 4..7 capture words at 0x330..0x33c, vector in bits 7:0.
// - capture bit 8 is 1 when a bus error ended the fetch, else 0.
// - a level is acknowledged only while its enable bit is set.
// - after a capture, no new acknowledge at that level until status cleared.
// - local map steers each source to one of eight local outputs.
// - local code zero means output 0, higher codes that numbered output.
// - local map fields: monitors 3..0 at 30:28..18:16, mailboxes 14:12..2:0.
// - backplane map steers each mailbox source to one of seven lines.
// - backplane code n drives request line n, for n from 1 to 7.
// - backplane code zero keeps the source off all backplane lines.
// - backplane map holds mailbox codes in 14:12..2:0, rest reserved.
// - mailbox zero is a 32-bit read/write word at 0x348, reset zero.
// - mailboxes one to three follow at 0x34c, 0x350, 0x354, reset zero.
package vmeirq_pkg;

    // register offsets, low twelve address bits
    localparam logic [11:0] VMEIRQ_LVL4_CAP_OFS  = 12'h330;
    localparam logic [11:0] VMEIRQ_LVL5_CAP_OFS  = 12'h334;
    localparam logic [11:0] VMEIRQ_LVL6_CAP_OFS  = 12'h338;
    localparam logic [11:0] VMEIRQ_LVL7_CAP_OFS  = 12'h33c;
    localparam logic [11:0] VMEIRQ_LOCAL_MAP_OFS = 12'h340;
    localparam logic [11:0] VMEIRQ_BP_MAP_OFS    = 12'h344;
    localparam logic [11:0] VMEIRQ_MESSAGE_BOX_ZERO_OFS     = 12'h348;
    localparam logic [11:0] VMEIRQ_MESSAGE_BOX_ONE_OFS     = 12'h34c;
    localparam logic [11:0] VMEIRQ_MESSAGE_BOX_TWO_OFS     = 12'h350;
    localparam logic [11:0] VMEIRQ_MESSAGE_BOX_THREE_OFS     = 12'h354;
    localparam logic [11:0] VMEIRQ_ENABLE_OFS    = 12'h380;
    localparam logic [11:0] VMEIRQ_STATUS_OFS    = 12'h384;

    // field layout
    localparam int VMEIRQ_VEC_W        = 8;
    localparam int VMEIRQ_ERR_BIT      = 8;
    localparam int VMEIRQ_CODE_W       = 3;
    localparam int VMEIRQ_FIELD_STRIDE = 4;
    localparam int VMEIRQ_LM_FIELD0    = 4;
    localparam int VMEIRQ_HANDLER_LSB  = 4;
    localparam int VMEIRQ_NUM_LEVELS   = 4;
    localparam int VMEIRQ_NUM_MBOX     = 4;
    localparam int VMEIRQ_LOCAL_OUTS   = 8;
    localparam int VMEIRQ_BP_LINES     = 7;
    localparam logic [31:0] VMEIRQ_LOCAL_MAP_MASK = 32'h7777_7777;
    localparam logic [31:0] VMEIRQ_BP_MAP_MASK    = 32'h0000_7777;
    localparam logic [2:0]  VMEIRQ_FIRST_LEVEL    = 3'h4;

    // reset values
    localparam logic [31:0] VMEIRQ_REG_RESET  = 32'h0000_0000;
    localparam logic [3:0]  VMEIRQ_FLAG_RESET = 4'h0;

    // answer of the interrupter being acknowledged
    typedef struct packed {
        logic       done;
        logic       berr;
        logic [7:0] vector;
    } vmeirq_ack_rsp_type;

    // one level's capture word
    typedef struct packed {
        logic       err;
        logic [7:0] vector;
    } vmeirq_capture_type;

    typedef enum logic {VMEIRQ_IDLE, VMEIRQ_WAIT} vmeirq_ack_state_type;

    // pick a routing code out of a map word
    function automatic logic [2:0] vmeirq_code(input logic [31:0] map,
                                               input int          field);
        vmeirq_code = map[field * VMEIRQ_FIELD_STRIDE +: VMEIRQ_CODE_W];
    endfunction : vmeirq_code

endpackage : vmeirq_pkg

// ===== verilog/vmeirq_route.sv
`timescale 1ns/1ps
// registered source-to-line router, one code per source
module vmeirq_route #(
    parameter int NSRC = 8,
    parameter int NOUT = 8,
    parameter int BASE = 0
) (
    input  wire logic            hclk,
    input  wire logic            hresetn,
    input  wire logic [31:0]     map,
    input  wire logic [NSRC-1:0] src,
    output logic      [NOUT-1:0] lines
);
    import vmeirq_pkg::*;

    logic [NOUT-1:0] next_lines;

    // line o answers code o+BASE; with BASE 1 code zero hits nothing
    always_comb
    begin
        next_lines = '0;
        for (int s = 0; s < NSRC; s++)
        begin
            for (int o = 0; o < NOUT; o++)
            begin
                if (src[s] && vmeirq_code(map, s) == 3'(o + BASE))
                    next_lines[o] = 1'b1;
            end
        end
    end

    // registered so outputs never glitch on map writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            lines <= '0;
        else
            lines <= next_lines;
    end

endmodule : vmeirq_route

// ===== verilog/vmeirq_ack.sv
`timescale 1ns/1ps
// acknowledge sequencer: one cycle in flight, highest level first
module vmeirq_ack (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [3:0] pending,
    input  wire logic [3:0] enable,
    input  wire logic [3:0] status,
    input  wire logic       rsp_done,
    output logic            iack_req,
    output logic [2:0]      iack_level,
    output logic [3:0]      cap_we
);
    import vmeirq_pkg::*;

    vmeirq_ack_state_type state;
    logic [1:0]           sel;
    logic [3:0]           eligible;
    logic [1:0]           pick;

    // a level waits while disabled or while its status is uncleared
    assign eligible = pending & enable & ~status;

    // priority: level 7 beats level 4
    always_comb
    begin
        pick = 2'h0;
        for (int i = 0; i < VMEIRQ_NUM_LEVELS; i++)
        begin
            if (eligible[i])
                pick = 2'(i);
        end
    end

    // capture strobe in the cycle the answer arrives
    always_comb
    begin
        cap_we = '0;
        if (state == VMEIRQ_WAIT && rsp_done)
            cap_we[sel] = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state      <= VMEIRQ_IDLE;
            sel        <= 2'h0;
            iack_req   <= 1'b0;
            iack_level <= 3'h0;
        end
        else
        begin
            case (state)
                VMEIRQ_IDLE:
                    if (|eligible)
                    begin
                        state      <= VMEIRQ_WAIT;
                        sel        <= pick;
                        iack_req   <= 1'b1;
                        iack_level <= VMEIRQ_FIRST_LEVEL + {1'b0, pick};
                    end
                VMEIRQ_WAIT:
                    if (rsp_done)
                    begin
                        state    <= VMEIRQ_IDLE;
                        iack_req <= 1'b0;
                    end
                default:
                    state <= VMEIRQ_IDLE;
            endcase
        end
    end

endmodule : vmeirq_ack

// ===== verilog/vmeirq_top.sv
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
// vector capture, interrupt routing and mailboxes behind an ahb-lite slave
module vmeirq_top (
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic      [31:0]                   hrdata,
    input  wire logic [3:0]                    backplane_irq_pending,
    input  wire vmeirq_pkg::vmeirq_ack_rsp_type iack_rsp,
    output logic                               iack_req,
    output logic      [2:0]                    iack_level,
    input  wire logic [3:0]                    mailbox_irq_src,
    input  wire logic [3:0]                    loc_monitor_irq_src,
    output logic      [7:0]                    local_irq_output,
    output logic      [6:0]                    backplane_irq_request_line
);
    import vmeirq_pkg::*;

    logic                take;
    logic                rd_pend;
    logic                wr_pend;
    logic [11:0]         addr_q;
    logic [31:0]         rd_word;
    logic [3:0]          pend_meta;
    logic [3:0]          pend_sync;
    logic [3:0]          cap_we;
    logic [3:0]          status_clr;
    logic [3:0]          next_status;
    logic [3:0]          local_irq_enable_reg;
    logic [3:0]          local_irq_status_reg;
    logic [31:0]         local_irq_route_map_b;
    logic [31:0]         backplane_irq_route_map_b;
    logic [31:0]         message_box [VMEIRQ_NUM_MBOX];
    vmeirq_capture_type  level_vector_capture [VMEIRQ_NUM_LEVELS];

    // request pins come from the backplane, so two flops first
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_meta <= 4'h0;
            pend_sync <= 4'h0;
        end
        else
        begin
            pend_meta <= backplane_irq_pending;
            pend_sync <= pend_meta;
        end
    end

    // address phase; size is ignored since only words are mapped
    assign take = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_q  <= 12'h000;
            rd_pend <= 1'b0;
            wr_pend <= 1'b0;
        end
        else
        begin
            rd_pend <= take && !hwrite;
            wr_pend <= take && hwrite;
            if (take)
                addr_q <= haddr[11:0];
        end
    end

    // one wait state on reads so a write just before is always seen
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= VMEIRQ_REG_RESET;
        end
        else
        begin
            hresp     <= 1'b0;
            hreadyout <= !(take && !hwrite);
            if (rd_pend)
                hrdata <= rd_word;
        end
    end

    // read decode; unmapped and reserved bits read zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (addr_q)
            VMEIRQ_LVL4_CAP_OFS: rd_word[8:0] = level_vector_capture[0];
            VMEIRQ_LVL5_CAP_OFS: rd_word[8:0] = level_vector_capture[1];
            VMEIRQ_LVL6_CAP_OFS: rd_word[8:0] = level_vector_capture[2];
            VMEIRQ_LVL7_CAP_OFS: rd_word[8:0] = level_vector_capture[3];
            VMEIRQ_LOCAL_MAP_OFS: rd_word = local_irq_route_map_b;
            VMEIRQ_BP_MAP_OFS: rd_word = backplane_irq_route_map_b;
            VMEIRQ_MESSAGE_BOX_ZERO_OFS: rd_word = message_box[0];
            VMEIRQ_MESSAGE_BOX_ONE_OFS: rd_word = message_box[1];
            VMEIRQ_MESSAGE_BOX_TWO_OFS: rd_word = message_box[2];
            VMEIRQ_MESSAGE_BOX_THREE_OFS: rd_word = message_box[3];
            VMEIRQ_ENABLE_OFS:
                rd_word[VMEIRQ_HANDLER_LSB +: 4] = local_irq_enable_reg;
            VMEIRQ_STATUS_OFS:
                rd_word[VMEIRQ_HANDLER_LSB +: 4] = local_irq_status_reg;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // routing maps keep only their code fields
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            local_irq_route_map_b     <= VMEIRQ_REG_RESET;
            backplane_irq_route_map_b <= VMEIRQ_REG_RESET;
        end
        else if (wr_pend)
        begin
            if (addr_q == VMEIRQ_LOCAL_MAP_OFS)
                local_irq_route_map_b <= hwdata & VMEIRQ_LOCAL_MAP_MASK;
            if (addr_q == VMEIRQ_BP_MAP_OFS)
                backplane_irq_route_map_b <= hwdata & VMEIRQ_BP_MAP_MASK;
        end
    end

    // mailboxes: plain words at consecutive offsets
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < VMEIRQ_NUM_MBOX; i++)
                message_box[i] <= VMEIRQ_REG_RESET;
        end
        else if (wr_pend)
        begin
            case (addr_q)
                VMEIRQ_MESSAGE_BOX_ZERO_OFS: message_box[0] <= hwdata;
                VMEIRQ_MESSAGE_BOX_ONE_OFS: message_box[1] <= hwdata;
                VMEIRQ_MESSAGE_BOX_TWO_OFS: message_box[2] <= hwdata;
                VMEIRQ_MESSAGE_BOX_THREE_OFS: message_box[3] <= hwdata;
                default: ;
            endcase
        end
    end

    // per-level handler enables
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            local_irq_enable_reg <= VMEIRQ_FLAG_RESET;
        else if (wr_pend && addr_q == VMEIRQ_ENABLE_OFS)
            local_irq_enable_reg <= hwdata[VMEIRQ_HANDLER_LSB +: 4];
    end

    // status is write-one-to-clear; a capture in the same cycle wins
    assign status_clr = (wr_pend && addr_q == VMEIRQ_STATUS_OFS)
                      ? hwdata[VMEIRQ_HANDLER_LSB +: 4] : 4'h0;
    assign next_status = (local_irq_status_reg & ~status_clr) | cap_we;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            local_irq_status_reg <= VMEIRQ_FLAG_RESET;
        else
            local_irq_status_reg <= next_status;
    end

    // capture words hold vector and error flag until the next capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < VMEIRQ_NUM_LEVELS; i++)
                level_vector_capture[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < VMEIRQ_NUM_LEVELS; i++)
            begin
                if (cap_we[i])
                    level_vector_capture[i] <= {iack_rsp.berr,
                                                iack_rsp.vector};
            end
        end
    end

    // acknowledge sequencing relies on the partner answering
    vmeirq_ack u_ack (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pending    (pend_sync),
        .enable     (local_irq_enable_reg),
        .status     (local_irq_status_reg),
        .rsp_done   (iack_rsp.done),
        .iack_req   (iack_req),
        .iack_level (iack_level),
        .cap_we     (cap_we)
    );

    // local outputs: mailboxes are fields 0..3, monitors fields 4..7
    vmeirq_route #(
        .NSRC (VMEIRQ_NUM_MBOX * 2),
        .NOUT (VMEIRQ_LOCAL_OUTS),
        .BASE (0)
    ) u_local_route (
        .hclk    (hclk),
        .hresetn (hresetn),
        .map     (local_irq_route_map_b),
        .src     ({loc_monitor_irq_src, mailbox_irq_src}),
        .lines   (local_irq_output)
    );

    // backplane lines 1..7 sit at bits 0..6
    vmeirq_route #(
        .NSRC (VMEIRQ_NUM_MBOX),
        .NOUT (VMEIRQ_BP_LINES),
        .BASE (1)
    ) u_bp_route (
        .hclk    (hclk),
        .hresetn (hresetn),
        .map     (backplane_irq_route_map_b),
        .src     (mailbox_irq_src),
        .lines   (backplane_irq_request_line)
    );

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence seq_answer;
        iack_req && iack_rsp.done;
    endsequence

    sequence seq_word_write(logic [11:0] ofs);
        wr_pend && addr_q == ofs;
    endsequence

    sequence seq_ack_open;
        iack_req && !iack_rsp.done;
    endsequence

    // vector and error flag land in the acknowledged level's word
    AST_CAPTURE_VECTOR: assert property (
        seq_answer |=> level_vector_capture[$past(iack_level[1:0])].vector
                       == $past(iack_rsp.vector))
        else $error("captured vector differs from answer");

    AST_CAPTURE_ERR: assert property (
        seq_answer |=> level_vector_capture[$past(iack_level[1:0])].err
                       == $past(iack_rsp.berr))
        else $error("capture error flag differs from answer");

    // level 4 word reads back at its offset two edges after the address
    AST_READ_LEVEL4: assert property (
        take && !hwrite && haddr[11:0] == VMEIRQ_LVL4_CAP_OFS
        |=> !hreadyout ##1 hreadyout
            && hrdata == {23'h0, $past(level_vector_capture[0])})
        else $error("level 4 capture read wrong");

    // old enable and status, indexed by the level just started
    AST_ACK_ENABLED: assert property (
        $rose(iack_req) |->
            ($past(local_irq_enable_reg) & (4'h1 << iack_level[1:0])) != 4'h0)
        else $error("acknowledge started on a disabled level");

    AST_ACK_STATUS_CLEAR: assert property (
        $rose(iack_req) |->
            ($past(local_irq_status_reg) & (4'h1 << iack_level[1:0])) == 4'h0)
        else $error("acknowledge started before status cleared");

    AST_LOCAL_ZERO_CODE: assert property (
        mailbox_irq_src[0] && local_irq_route_map_b[2:0] == 3'h0
        |=> local_irq_output[0])
        else $error("local code zero did not reach output 0");

    AST_LOCAL_MONITOR3: assert property (
        loc_monitor_irq_src[3] && local_irq_route_map_b[30:28] == 3'h5
        |=> local_irq_output[5])
        else $error("monitor 3 not routed by bits 30:28");

    AST_BP_LINE: assert property (
        mailbox_irq_src[1] && backplane_irq_route_map_b[6:4] == 3'h3
        |=> backplane_irq_request_line[2])
        else $error("backplane code 3 did not drive line 3");

    AST_BP_SUPPRESS: assert property (
        backplane_irq_route_map_b == 32'h0000_0000
        |=> backplane_irq_request_line == 7'h00)
        else $error("backplane code zero raised a line");

    AST_MESSAGE_BOX_ZERO_WRITE: assert property (
        seq_word_write(VMEIRQ_MESSAGE_BOX_ZERO_OFS) |=> message_box[0] == $past(hwdata))
        else $error("mailbox zero write lost");

    AST_MESSAGE_BOX_ONE_WRITE: assert property (
        seq_word_write(VMEIRQ_MESSAGE_BOX_ONE_OFS) |=> message_box[1] == $past(hwdata))
        else $error("mailbox one write lost");

    AST_BP_RESERVED: assert property (
        backplane_irq_route_map_b[31:15] == 17'h0
        && local_irq_route_map_b[31] == 1'b0)
        else $error("reserved map bits not zero");

    // an open acknowledge keeps its level until answered
    AST_ACK_HOLD: assert property (
        seq_ack_open |=> iack_req && $stable(iack_level))
        else $error("acknowledge dropped before its answer");

    AST_STATUS_SET: assert property (
        seq_answer |=> local_irq_status_reg[$past(iack_level[1:0])])
        else $error("status bit not set by capture");

    // the level 7 capture word changes only on its own answer
    AST_CAPTURE_HOLD: assert property (
        !cap_we[3] |=> $stable(level_vector_capture[3]))
        else $error("level 7 capture changed without answer");

    AST_LOCAL_CODE7: assert property (
        mailbox_irq_src[3] && local_irq_route_map_b[14:12] == 3'h7
        |=> local_irq_output[7])
        else $error("local code 7 did not reach output 7");

    AST_LOCAL_MAP_WRITE: assert property (
        seq_word_write(VMEIRQ_LOCAL_MAP_OFS) |=> local_irq_route_map_b
            == ($past(hwdata) & VMEIRQ_LOCAL_MAP_MASK))
        else $error("local map write lost");

    AST_BP_MAP_WRITE: assert property (
        seq_word_write(VMEIRQ_BP_MAP_OFS) |=> backplane_irq_route_map_b
            == ($past(hwdata) & VMEIRQ_BP_MAP_MASK))
        else $error("backplane map write lost");

    AST_MESSAGE_BOX_TWO_WRITE: assert property (
        seq_word_write(VMEIRQ_MESSAGE_BOX_TWO_OFS) |=> message_box[2] == $past(hwdata))
        else $error("mailbox two write lost");

    AST_MESSAGE_BOX_THREE_WRITE: assert property (
        seq_word_write(VMEIRQ_MESSAGE_BOX_THREE_OFS) |=> message_box[3] == $past(hwdata))
        else $error("mailbox three write lost");

endmodule : vmeirq_top

// ===== verif/vmeirq_intr_model.sv
`timescale 1ns/1ps
// interrupter on the backplane: answers each acknowledge after a delay
module vmeirq_intr_model (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      iack_req,
    input  wire logic [2:0]                iack_level,
    input  wire logic [1:0]                delay,
    input  wire logic [7:0]                vec_base,
    input  wire logic [3:0]                berr_lvl,
    output vmeirq_pkg::vmeirq_ack_rsp_type rsp
);
    import vmeirq_pkg::*;

    logic [1:0] wait_cnt;

    // one done pulse per acknowledge; data lines toggle when not valid
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wait_cnt <= 2'h0;
            rsp      <= '0;
        end
        else
        begin
            rsp.done   <= 1'b0;
            rsp.berr   <= ~rsp.berr;
            rsp.vector <= ~rsp.vector;
            if (iack_req && !rsp.done)
            begin
                wait_cnt <= wait_cnt + 2'h1;
                if (wait_cnt >= delay)
                begin
                    wait_cnt   <= 2'h0;
                    rsp.done   <= 1'b1;
                    rsp.vector <= vec_base ^ {5'h0, iack_level};
                    rsp.berr   <= berr_lvl[iack_level[1:0]];
                end
            end
        end
    end
endmodule : vmeirq_intr_model

// ===== verif/testbench.sv
`timescale 1ns/1ps
// bench: registers over the bus, routing, and vector capture
module testbench;
    import vmeirq_pkg::*;

    logic               hclk, hresetn, hsel, hwrite, hready, hresp;
    logic [31:0]        haddr, hwdata, hrdata, rng, lmap, bmap;
    logic [1:0]         htrans, delay;
    logic [2:0]         hsize, iack_level;
    logic [3:0]         pend, mbox_src, lm_src, berr_lvl;
    logic [7:0]         local_out, vec_base;
    logic [6:0]         bp_out;
    logic               iack_req, req_q;
    vmeirq_ack_rsp_type rsp;
    int                 error_cnt = 0, samples_checked = 0, acks = 0;

    vmeirq_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .backplane_irq_pending(pend),
        .iack_rsp(rsp), .iack_req(iack_req), .iack_level(iack_level),
        .mailbox_irq_src(mbox_src), .loc_monitor_irq_src(lm_src),
        .local_irq_output(local_out), .backplane_irq_request_line(bp_out));

    vmeirq_intr_model partner (.hclk(hclk), .hresetn(hresetn),
        .iack_req(iack_req), .iack_level(iack_level), .delay(delay),
        .vec_base(vec_base), .berr_lvl(berr_lvl), .rsp(rsp));

    initial hclk = 1'b0;
    always #20 hclk = ~hclk;

    // count acknowledge starts, sampled away from the active edge
    always @(negedge hclk)
    begin
        if (iack_req === 1'b1 && req_q !== 1'b1)
            acks++;
        req_q = iack_req;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    endfunction : xs

    // fields 0..3 mailboxes, 4..7 monitors
    function automatic logic [7:0] exp_local(input logic [31:0] m,
                                             input logic [7:0]  s);
        exp_local = 8'h00;
        for (int i = 0; i < 8; i++)
            if (s[i])
                exp_local[m[i*4 +: 3]] = 1'b1;
    endfunction : exp_local

    // code n lights line n; zero lights nothing
    function automatic logic [6:0] exp_bp(input logic [31:0] m,
                                          input logic [3:0]  s);
        exp_bp = 7'h00;
        for (int i = 0; i < 4; i++)
            if (s[i] && m[i*4 +: 3] != 3'h0)
                exp_bp[m[i*4 +: 3] - 3'h1] = 1'b1;
    endfunction : exp_bp

    task automatic check(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask : check

    // one transfer; hready is read at the negedge before each edge
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        logic rdy;
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do
        begin
            @(negedge hclk) rdy = hready;
            @(posedge hclk);
        end while (rdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do
        begin
            @(negedge hclk) rdy = hready;
            q = hrdata;
            @(posedge hclk);
        end while (rdy !== 1'b1);
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(e, q);
        check(32'h0, {31'h0, hresp});
    endtask : rd

    // poll status until it settles, bounded
    task automatic wait_stat(input logic [31:0] e);
        logic [31:0] q;
        int          n;
        n = 0;
        do
        begin
            bus(1'b0, 32'h384, 32'h0, q);
            n++;
        end while (q !== e && n < 50);
        check(e, q);
    endtask : wait_stat

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    // watchdog far beyond the few hundred cycles expected
    initial
    begin
        #(40 * 20000);
        error_cnt++;
        close_out();
    end

    initial
    begin
        {hresetn, hsel, hwrite} = 3'h0;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
        {pend, mbox_src, lm_src, berr_lvl} = 16'h0;
        {vec_base, delay} = 10'h0;
        rng = 32'h0000_0f0d;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // every word from 0x330 to 0x354, reserved bits included, clear after reset
        for (logic [31:0] a = 32'h330; a <= 32'h354; a += 32'h4)
            rd(a, 32'h0);
        // mailboxes, written first so aliasing would show
        for (logic [31:0] a = 32'h348; a <= 32'h354; a += 32'h4)
            wr(a, a ^ rng);
        for (logic [31:0] a = 32'h348; a <= 32'h354; a += 32'h4)
            rd(a, a ^ rng);
        wr(32'h358, 32'hffff_ffff);
        rd(32'h358, 32'h0);
        wr(32'h330, 32'hffff_ffff);
        rd(32'h330, 32'h0);
        wr(32'h340, 32'hffff_ffff);
        rd(32'h340, 32'h7777_7777);
        wr(32'h344, 32'hffff_ffff);
        rd(32'h344, 32'h0000_7777);
        // every code in field zero of both maps, random elsewhere
        for (int i = 0; i < 8; i++)
        begin
            rng = xs(rng);
            lmap = (rng & 32'h7777_7770) | 32'(i);
            bmap = (rng & 32'h0000_7770) | 32'(i);
            wr(32'h340, lmap);
            wr(32'h344, bmap);
            rng = xs(rng);
            {lm_src, mbox_src} <= rng[7:0] | 8'h01;
            repeat (3) @(posedge hclk);
            @(negedge hclk);
            check({24'h0, exp_local(lmap, {lm_src, mbox_src})},
                  {24'h0, local_out});
            check({25'h0, exp_bp(bmap, mbox_src)}, {25'h0, bp_out});
            @(posedge hclk);
        end
        // corner: monitor 3 code 5, mailbox 3 code 7, mailbox 1 line 3
        wr(32'h340, 32'h5000_7000);
        wr(32'h344, 32'h0000_0030);
        {lm_src, mbox_src} <= 8'h8a;
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        check(32'ha1, {24'h0, local_out});
        check(32'h04, {25'h0, bp_out});
        @(posedge hclk);
        // pending but disabled: never acknowledged
        pend <= 4'hf;
        repeat (20) @(posedge hclk);
        check(32'h0, 32'(acks));
        rng = xs(rng);
        {vec_base, delay, berr_lvl} <= {rng[7:0], rng[9:8], 4'h4};
        wr(32'h380, 32'h50);
        wait_stat(32'h50);
        check(32'h2, 32'(acks));
        rd(32'h330, {24'h0, vec_base ^ 8'h04});
        rd(32'h338, {23'h1, vec_base ^ 8'h06});
        rd(32'h334, 32'h0);
        // clearing one status bit allows exactly one more acknowledge
        {vec_base, delay} <= {vec_base + 8'h11, rng[11:10]};
        wr(32'h384, 32'h10);
        wait_stat(32'h50);
        check(32'h3, 32'(acks));
        rd(32'h330, {24'h0, vec_base ^ 8'h04});
        // all four levels with random bus errors
        rng = xs(rng);
        {vec_base, delay, berr_lvl} <= rng[13:0];
        wr(32'h380, 32'hf0);
        wr(32'h384, 32'hf0);
        wait_stat(32'hf0);
        check(32'h7, 32'(acks));
        for (int l = 0; l < 4; l++)
            rd(32'h330 + 32'(l * 4),
               {23'h0, berr_lvl[l], vec_base ^ 8'(l + 4)});
        pend <= 4'h0;
        close_out();
    end
endmodule : testbench
